// >>> pkg/fsp_consts.vh
// Constants for the flash sector protection block
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH
// ----------------------------------------
// Address map
// ----------------------------------------
`define FSP_ADDR_W 16
`define FSP_SECTOR_SIZE 16'h1000
`define FSP_SEC0_BASE 16'hF000
`define FSP_SEC1_BASE 16'hE000
`define FSP_SIZE_4K 2'h0
`define FSP_SIZE_8K 2'h1
`define FSP_SIZE_BIG 2'h2
`define FSP_SEC_NONE 2'h3
// ----------------------------------------
// Programming modes
// ----------------------------------------
`define FSP_MODE_TOOL 2'h0
`define FSP_MODE_ICP 2'h1
`define FSP_MODE_IAP 2'h2
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define FSP_OP_PROG 2'h0
`define FSP_OP_SECT_ERASE 2'h1
`define FSP_OP_BLOCK_ERASE 2'h2
`define FSP_OP_OPTION 2'h3
// ----------------------------------------
// Option byte layout and reset value
// ----------------------------------------
`define FSP_OPT_RDP_BIT 0
`define FSP_OPT_RESET 8'hFF
`define FSP_ERASED_BYTE 8'hFF
`endif

// >>> verilog/fsp_sector_decode.v
// Address to sector decode with size-dependent sector count
`timescale 1ns/10ps
module fsp_sector_decode
(
  input wire [15:0] addr,
  input wire [1:0] flashSize,
  output reg [1:0] sector,
  output reg inArray
);
`include "fsp_consts.vh"
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always @*
  begin
    sector = `FSP_SEC_NONE;
    inArray = 1'b0;
    if (addr >= `FSP_SEC0_BASE)
    begin
      sector = 2'h0;
      inArray = 1'b1;
    end
    else if (addr >= `FSP_SEC1_BASE)
    begin
      if (flashSize != `FSP_SIZE_4K)
      begin
        sector = 2'h1;
        inArray = 1'b1;
      end
    end
    else if (flashSize == `FSP_SIZE_BIG)
    begin
      sector = 2'h2;
      inArray = 1'b1;
    end
  end
endmodule

// >>> verilog/fsp_link_sync.v
// Link pin synchroniser and serial clock edge finder
`timescale 1ns/10ps
module fsp_link_sync
(
  input wire sys_clk,
  input wire rst,
  input wire serClkPin,
  input wire serDataPin,
  output reg serClkRise,
  output reg serDataSync
);
  reg [1:0] clkSync_reg;
  reg [1:0] dataSync_reg;
  reg clkLast_reg;
  // ----------------------------------------
  // Two-stage sync; first stage read only by second
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      clkSync_reg <= 2'h0;
      dataSync_reg <= 2'h0;
      clkLast_reg <= 1'b0;
      serClkRise <= 1'b0;
      serDataSync <= 1'b0;
    end
    else
    begin
      clkSync_reg <= {clkSync_reg[0], serClkPin};
      dataSync_reg <= {dataSync_reg[0], serDataPin};
      clkLast_reg <= clkSync_reg[1];
      serClkRise <= clkSync_reg[1] & ~clkLast_reg;
      serDataSync <= dataSync_reg[1];
    end
  end
endmodule

// >>> verilog/fsp_flash_ctrl.v
// Flash access and protection controller
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/10ps
module fsp_flash_ctrl
#(
  parameter MEM_DEPTH = 256,
  parameter IDX_W = 8
)
(
  input wire sys_clk,
  input wire rst,
  input wire [1:0] flashSize,
  input wire [1:0] progMode,
  input wire reqValid,
  input wire [1:0] reqOp,
  input wire [15:0] reqAddr,
  input wire [7:0] reqData,
  input wire extRead,
  input wire [15:0] rdAddr,
  input wire incircuit_serial_clock,
  input wire incircuit_serial_data,
  input wire toolAttached,
  output reg [7:0] rdData,
  output reg rdValid,
  output reg reqDone,
  output reg reqRefused,
  output reg busy,
  output reg readout_protect_option_bit,
  output reg linkClkEdge,
  output reg linkDataSync,
  output reg appPinsBlocked
);
`include "fsp_consts.vh"
  localparam ST_IDLE = 2'h0;
  localparam ST_ERASE = 2'h1;
  // Kept at full width; the counter is widened to meet it
  localparam integer IDX_LAST = MEM_DEPTH - 1;
  // ----------------------------------------
  // Storage: low index bits of each sector window
  // ----------------------------------------
  reg [7:0] mem_reg [0:3*MEM_DEPTH-1];
  reg [7:0] option_reg;
  reg [1:0] state_reg;
  reg [IDX_W-1:0] idx_reg;
  reg [1:0] eraseSec_reg;
  reg eraseAll_reg;
  reg pendOpt_reg;
  reg [7:0] pendVal_reg;
  wire [1:0] reqSector;
  wire reqInArray;
  wire [1:0] rdSector;
  wire rdInArray;
  wire clkRise;
  wire dataSync;
  wire protOn;
  reg allowed;
  fsp_sector_decode uReqDec
  (
    .addr(reqAddr),
    .flashSize(flashSize),
    .sector(reqSector),
    .inArray(reqInArray)
  );
  fsp_sector_decode uRdDec
  (
    .addr(rdAddr),
    .flashSize(flashSize),
    .sector(rdSector),
    .inArray(rdInArray)
  );
  fsp_link_sync uSync
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .serClkPin(incircuit_serial_clock),
    .serDataPin(incircuit_serial_data),
    .serClkRise(clkRise),
    .serDataSync(dataSync)
  );
  assign protOn = ~option_reg[`FSP_OPT_RDP_BIT];

  // ----------------------------------------
  // Erase target per sector
  // ----------------------------------------
  wire [2:0] eraseHit;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gEraseHit
      assign eraseHit[g] = eraseAll_reg || ({30'h00000000, eraseSec_reg} == g);
    end
  endgenerate
  // ----------------------------------------
  // Permission check
  // ----------------------------------------
  always @*
  begin
    allowed = 1'b0;
    if (reqOp == `FSP_OP_OPTION)
    begin
      // option only off-board
      // Option stays writable while locked, else no unlock path
      allowed = (progMode != `FSP_MODE_IAP);
    end
    else if (protOn)
    begin
      allowed = 1'b0;
    end
    else if (reqOp == `FSP_OP_BLOCK_ERASE)
    begin
      allowed = (progMode != `FSP_MODE_IAP);
    end
    else if (reqInArray)
    begin
      allowed = !((progMode == `FSP_MODE_IAP) && (reqSector == 2'h0));
    end
  end
  // ----------------------------------------
  // Request engine
  // ----------------------------------------
  integer i;
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      idx_reg <= {IDX_W{1'b0}};
      eraseSec_reg <= 2'h0;
      eraseAll_reg <= 1'b0;
      pendOpt_reg <= 1'b0;
      pendVal_reg <= 8'h00;
      option_reg <= `FSP_OPT_RESET;
      reqDone <= 1'b0;
      reqRefused <= 1'b0;
      busy <= 1'b0;
      readout_protect_option_bit <= 1'b1;
    end
    else
    begin
      reqDone <= 1'b0;
      reqRefused <= 1'b0;
      readout_protect_option_bit <= option_reg[`FSP_OPT_RDP_BIT];
      case (state_reg)
        ST_IDLE:
        begin
          if (reqValid)
          begin
            if (!allowed)
            begin
              reqRefused <= 1'b1;
            end
            else if (reqOp == `FSP_OP_OPTION)
            begin
              // unprotect erases all first
              // Option loads only after the erase, so no byte outlives the lock
              if (protOn && reqData[`FSP_OPT_RDP_BIT])
              begin
                pendOpt_reg <= 1'b1;
                pendVal_reg <= reqData;
                eraseAll_reg <= 1'b1;
                idx_reg <= {IDX_W{1'b0}};
                state_reg <= ST_ERASE;
                busy <= 1'b1;
              end
              else
              begin
                option_reg <= reqData;
                reqDone <= 1'b1;
              end
            end
            else if (reqOp == `FSP_OP_PROG)
            begin
              mem_reg[reqSector*MEM_DEPTH + reqAddr[IDX_W-1:0]] <= reqData;
              reqDone <= 1'b1;
            end
            else
            begin
              eraseAll_reg <= (reqOp == `FSP_OP_BLOCK_ERASE);
              eraseSec_reg <= reqSector;
              idx_reg <= {IDX_W{1'b0}};
              state_reg <= ST_ERASE;
              busy <= 1'b1;
            end
          end
        end
        ST_ERASE:
        begin
          for (i = 0; i < 3; i = i + 1)
          begin
            if (eraseHit[i])
            begin
              mem_reg[i*MEM_DEPTH + idx_reg] <= `FSP_ERASED_BYTE;
            end
          end
          if ({{(32-IDX_W){1'b0}}, idx_reg} == IDX_LAST)
          begin
            state_reg <= ST_IDLE;
            busy <= 1'b0;
            reqDone <= 1'b1;
            eraseAll_reg <= 1'b0;
            if (pendOpt_reg)
            begin
              option_reg <= pendVal_reg;
              pendOpt_reg <= 1'b0;
            end
          end
          else
          begin
            idx_reg <= idx_reg + {{(IDX_W-1){1'b0}}, 1'b1};
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdData <= 8'h00;
      rdValid <= 1'b0;
    end
    else
    begin
      rdValid <= extRead;
      // extraction blocked, reads zero
      // Zero rather than stale data keeps a locked part opaque
      if (extRead && rdInArray && !protOn)
      begin
        rdData <= mem_reg[rdSector*MEM_DEPTH + rdAddr[IDX_W-1:0]];
      end
      else
      begin
        rdData <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Link status
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      linkClkEdge <= 1'b0;
      linkDataSync <= 1'b0;
    end
    else
    begin
      linkClkEdge <= clkRise;
      linkDataSync <= dataSync;
    end
  end

  // ----------------------------------------
  // Tool presence synchroniser
  // ----------------------------------------
  reg attachMeta_reg;
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      attachMeta_reg <= 1'b0;
      appPinsBlocked <= 1'b0;
    end
    else
    begin
      // Attach pin is asynchronous; only the second flop is read
      attachMeta_reg <= toolAttached;
      appPinsBlocked <= attachMeta_reg;
    end
  end
endmodule

// >>> tb/fsp_ctrl_props.sv
// Assertion checker for the flash access controller
`timescale 1ns/10ps
module fsp_ctrl_props #(parameter MEM_DEPTH = 16)
(
  input wire sys_clk,
  input wire rst,
  input wire [1:0] flashSize,
  input wire [1:0] progMode,
  input wire reqValid,
  input wire [1:0] reqOp,
  input wire [15:0] reqAddr,
  input wire [7:0] reqData,
  input wire incircuit_serial_clock,
  input wire reqDone,
  input wire reqRefused,
  input wire busy,
  input wire readout_protect_option_bit,
  input wire linkClkEdge
);
  // Erase walks one sector depth, so the run scales with the parameter
  localparam int RUN = MEM_DEPTH - 1;
  wire take = reqValid && !busy;
  wire sec0 = reqAddr[15:12] == 4'hF;
  wire appMode = progMode == 2'h2;
  wire unlk = readout_protect_option_bit;
  // The protect output lags the option by one cycle, marked by reqDone
  wire wrOk = take && !appMode && unlk && !reqDone;
  wire lockTake = take && !unlk && !reqDone;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence sEraseGo;
    wrOk && reqOp == 2'h1 && sec0;
  endsequence
  sequence sEraseRun;
    busy ##RUN busy ##1 (reqDone && !busy);
  endsequence
  a_erase_timing: assert property (sEraseGo |=> sEraseRun)
    else $error("erase timing wrong");
  a_app_sec0_refused: assert property (take && appMode && sec0 |=> reqRefused && !reqDone)
    else $error("sector zero write not refused");
  a_open_prog: assert property (wrOk && sec0 && reqOp == 2'h0 |=> reqDone)
    else $error("open write not done");
  a_locked_refused: assert property
    (lockTake && !$past(unlk) && reqOp != 2'h3 |=> reqRefused)
    else $error("locked write not refused");
  a_small_unmapped: assert property
    (take && flashSize == 2'h0 && !sec0 && reqOp == 2'h0 |=> reqRefused)
    else $error("unmapped write not refused");
  a_option_lock: assert property
    (take && !appMode && reqOp == 2'h3 && !reqData[0] |-> ##[1:2] !unlk)
    else $error("protect bit not set");
  a_unlock_erase: assert property
    (lockTake && !appMode && !$past(unlk) && reqOp == 2'h3 && reqData[0] |-> ##[1:3] busy)
    else $error("unlock without erase");
  a_link_edge: assert property ($rose(incircuit_serial_clock) |-> ##[3:5] linkClkEdge)
    else $error("link edge missed");
endmodule
bind fsp_flash_ctrl fsp_ctrl_props #(.MEM_DEPTH(MEM_DEPTH)) u_props (.sys_clk, .rst, .flashSize,
  .progMode, .reqValid, .reqOp, .reqAddr, .reqData, .incircuit_serial_clock, .reqDone,
  .reqRefused, .busy, .readout_protect_option_bit, .linkClkEdge);

// >>> tb/fsp_tool_model.sv
// Programming tool model on the in-circuit serial link
`timescale 1ns/10ps
module fsp_tool_model
(
  output reg incircuit_serial_clock,
  output reg incircuit_serial_data,
  output reg toolAttached
);
  integer i;
  initial
  begin
    incircuit_serial_clock = 1'h0;
    incircuit_serial_data = 1'h0;
    toolAttached = 1'h0;
  end
  task attach;
    #7 toolAttached = 1'h1;
  endtask
  task send(input [7:0] v);
    for (i = 7; i >= 0; i = i - 1)
    begin
      incircuit_serial_data = v[i];
      #40 incircuit_serial_clock = 1'h1;
      #40 incircuit_serial_clock = 1'h0;
    end
    // Released line must not keep showing the last bit
    incircuit_serial_data = ~v[0];
  endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the flash access controller
`timescale 1ns/10ps
module testbench;
  reg sys_clk = 1'h0, rst = 1'h1, reqValid = 1'h0, extRead = 1'h0;
  reg [1:0] flashSize = 2'h1, progMode = 2'h0, reqOp = 2'h0;
  reg [15:0] reqAddr = 16'h0000, rdAddr = 16'h0000, rxCount = 16'h0000;
  reg [7:0] reqData = 8'h00, rxByte = 8'h00;
  wire incircuit_serial_clock, incircuit_serial_data, toolAttached, rdValid, reqDone;
  wire reqRefused, busy, readout_protect_option_bit, linkClkEdge, linkDataSync, appPinsBlocked;
  wire [7:0] rdData;
  integer n_mismatch = 0, checked = 0, cycles = 0, i;
  always #2 sys_clk = ~sys_clk;
  fsp_tool_model tool (.incircuit_serial_clock, .incircuit_serial_data, .toolAttached);
  fsp_flash_ctrl #(.MEM_DEPTH(16), .IDX_W(4)) dut (.sys_clk, .rst, .flashSize, .progMode,
    .reqValid, .reqOp, .reqAddr, .reqData, .extRead, .rdAddr, .incircuit_serial_clock,
    .incircuit_serial_data, .toolAttached, .rdData, .rdValid, .reqDone, .reqRefused, .busy,
    .readout_protect_option_bit, .linkClkEdge, .linkDataSync, .appPinsBlocked);
  task end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (linkClkEdge === 1'h1)
      {rxByte, rxCount} = {rxByte[6:0], linkDataSync, rxCount + 16'h0001};
    if (cycles == 10000)
    begin
      n_mismatch = n_mismatch + 1;
      end_of_test;
    end
  end
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    checked = checked + 1;
    if (g !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value %0s expected %h seen %h", nm, e, g);
    end
  endtask
  // Trailing idle cycle keeps two strobes from landing in one step
  task req(input [1:0] op, input [15:0] a, input [7:0] d, input r);
    {reqValid, reqOp, reqAddr, reqData} = {1'h1, op, a, d};
    @(negedge sys_clk);
    reqValid = 1'h0;
    for (i = 0; i < 200 && !(reqDone | reqRefused); i = i + 1)
      @(negedge sys_clk);
    chk("reply", {r, !r}, {reqRefused, reqDone});
    @(negedge sys_clk);
  endtask
  task rd(input [15:0] a, input [7:0] e);
    {extRead, rdAddr} = {1'h1, a};
    @(negedge sys_clk);
    extRead = 1'h0;
    chk("rdValid", 1'h1, rdValid);
    chk("rdData", e, rdData);
    @(negedge sys_clk);
  endtask
  task t_prog;
    req(2'h1, 16'hF000, 8'h00, 1'h0);
    req(2'h1, 16'hE000, 8'h00, 1'h0);
    req(2'h0, 16'hFFFF, 8'hA5, 1'h0);
    req(2'h0, 16'hEFFF, 8'h3C, 1'h0);
    req(2'h1, 16'hE000, 8'h00, 1'h0);
    rd(16'hFFFF, 8'hA5);
    rd(16'hEFFF, 8'hFF);
    $display("test program and erase done");
  endtask
  task t_size;
    flashSize = 2'h0;
    req(2'h0, 16'hE001, 8'h11, 1'h1);
    flashSize = 2'h1;
    req(2'h0, 16'hD001, 8'h11, 1'h1);
    flashSize = 2'h2;
    req(2'h2, 16'hF000, 8'h00, 1'h0);
    req(2'h0, 16'hD001, 8'h77, 1'h0);
    rd(16'hD001, 8'h77);
    $display("test sector count done");
  endtask
  task t_app;
    progMode = 2'h2;
    req(2'h0, 16'hF002, 8'h12, 1'h1);
    req(2'h1, 16'hF000, 8'h00, 1'h1);
    req(2'h2, 16'hF000, 8'h00, 1'h1);
    req(2'h3, 16'hF000, 8'h00, 1'h1);
    req(2'h0, 16'hE002, 8'h34, 1'h0);
    rd(16'hF002, 8'hFF);
    $display("test application mode done");
  endtask
  task t_lock;
    progMode = 2'h1;
    req(2'h0, 16'hF005, 8'h66, 1'h0);
    req(2'h3, 16'hF000, 8'hFE, 1'h0);
    @(negedge sys_clk);
    chk("protect", 1'h0, readout_protect_option_bit);
    rd(16'hF005, 8'h00);
    req(2'h1, 16'hE000, 8'h00, 1'h1);
    req(2'h3, 16'hF000, 8'hFF, 1'h0);
    @(negedge sys_clk);
    chk("protect", 1'h1, readout_protect_option_bit);
    rd(16'hF005, 8'hFF);
    rd(16'hE002, 8'hFF);
    $display("test protection done");
  endtask
  task t_link;
    tool.attach;
    repeat (4) @(negedge sys_clk);
    chk("blocked", 1'h1, appPinsBlocked);
    tool.send(8'hB4);
    repeat (10) @(negedge sys_clk);
    chk("edges", 16'h0008, rxCount);
    chk("rxByte", 8'hB4, rxByte);
    $display("test serial link done");
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'h0;
    @(negedge sys_clk);
    t_prog;
    t_size;
    t_app;
    t_lock;
    t_link;
    end_of_test;
  end
endmodule
